// file: hw/flag_irq_pkg.sv
// Purpose: shared constants for the flag polarity and interrupt combiner
// Assumes: one 16-bit register port, word addressed by the printed offsets
// Notes: nothing here is logic; addresses, reset values and field positions of the block live here
package flag_irq_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [9:0] POL_ADDR = 10'h1c2; // flag polarity register
	localparam logic [9:0] CAUSE_ADDR = 10'h1d4; // interrupt cause register
	localparam int DATA_W = 16; // register data width
	localparam int FLAG_N = 13; // pin-mapped flag lines
	localparam logic [12:0] POL_RESET = 13'h0000; // polarity reset value
	localparam logic [12:0] CAUSE_RESET = 13'h0000; // cause reset value
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int START_LO = 3; // first start pin polarity bit
	localparam int START_HI = 8; // last start pin polarity bit
	localparam int START_N = 6; // number of start pins
	localparam int HALT_LO = 0; // halt bits 3..0
	localparam int REQ_LO = 4; // core request bits 7..4
	localparam int DRV_BIT = 8; // driver disable bit
	localparam int SPI_BIT = 9; // spi error bit
	localparam int CLK_BIT = 10; // clock loss bit
	localparam int SUM1_BIT = 11; // channel 1 checksum bit
	localparam int SUM2_BIT = 12; // channel 2 checksum bit
	localparam int SRC_N = 13; // interrupt source count
	// ************************************************************
	// combiner states
	// ************************************************************
	typedef enum logic [0:0] {
		IRQ_IDLE = 1'b0, // pin released
		IRQ_HELD = 1'b1 // pin asserted, cause frozen
	} irq_state_e;
endpackage

// file: hw/source_bus_if.sv
// Purpose: gated interrupt sources passed from gate stage to combiner
// Assumes: single clock domain
// Notes: carries the enabled request vector
`timescale 1ns/10ps
interface source_bus_if;
	logic [12:0] active; // enabled source levels, cause layout
	modport gate (output active);
	modport comb (input active);
endinterface

// file: hw/flag_pol_lane.sv
// Purpose: one flag lane polarity inversion
// Assumes: source select comes from the flag source block
// Notes: pass-through when the lane is not pin routed
`timescale 1ns/10ps
module flag_pol_lane (
	input wire logic routed,
	input wire logic invert,
	input wire logic fromPin,
	input wire logic fromCore,
	input wire logic dirIn,
	output logic toBus,
	output logic toPin
);
	// ************************************************************
	// lane mux
	// ************************************************************
	// inversion only when pin routed
	always_comb begin
		toPin = fromCore ^ (routed & invert);
		if (routed && dirIn) begin
			toBus = fromPin ^ invert;
		end else begin
			toBus = fromCore;
		end
	end
endmodule

// file: hw/flag_irq_top.sv
// Purpose: flag polarity register and interrupt combiner with cause latch
// Assumes: inputs synchronous to core_clk; register port word addressed
// Notes: the cause word freezes while the request pin is held low
// Function
// - 13-bit polarity register, 1 inverts flag
// - inversion only for pin-routed flags
// - unrouted flag bus driven by internal flag
// - bits 8..3 set start active level
// - request pin low while enabled source active
// - capture all sources on pin assertion
// - cause frozen while pin stays asserted
// - cause register readable over register port
// - no sources releases pin, clears cause
// - four core requests, each enabled
// - driver disable source, enabled
// - spi error source, enabled
// - clock loss source, enabled
// - channel checksum sources, enabled
// - halt bits 3..0 core order
// - request bits 7..4 core order
// - bits 8,9,10 driver, spi, clock
// - bits 11,12 chan1_code_sum_bad, ch2
`timescale 1ns/10ps
module flag_irq_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic [9:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regWdata,
	output logic [15:0] regRdata,
	// flag lanes
	input wire logic [12:0] flagRouted,
	input wire logic [12:0] flagDirIn,
	input wire logic [12:0] flagPinIn,
	input wire logic [12:0] intFlags,
	output logic [12:0] flagBus,
	output logic [12:0] flagPinOut,
	// start pins
	input wire logic [5:0] startPinIn,
	output logic [5:0] startActive,
	// interrupt sources and their enables
	input wire logic [3:0] coreHalted,
	input wire logic [3:0] coreRequest,
	input wire logic [3:0] coreReqEn,
	input wire logic driverDisabled,
	input wire logic driverIrqEn,
	input wire logic spiError,
	input wire logic spiIrqEn,
	input wire logic clockLost,
	input wire logic clockIrqEn,
	input wire logic [1:0] codeSumBad,
	input wire logic [1:0] codeSumIrqEn,
	// request toward the host, active low
	output logic host_request_n_pin
);
	// ************************************************************
	// polarity register
	// ************************************************************
	logic [12:0] polarity_r; // flag polarity bits
	logic [12:0] cause_r; // latched interrupt cause
	flag_irq_pkg::irq_state_e state_r; // combiner state
	source_bus_if srcBus ();

	// software write of polarity; cause writes dropped
	always_ff @(posedge core_clk) begin
		if (rst) begin
			polarity_r <= flag_irq_pkg::POL_RESET;
		end else if (regWr && regAddr == flag_irq_pkg::POL_ADDR) begin
			polarity_r <= regWdata[12:0];
		end
	end

	// ************************************************************
	// flag lanes
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < flag_irq_pkg::FLAG_N; gi++) begin : g_lane
			// routed lanes invert, others pass internal flag
			flag_pol_lane u_lane (
				.routed(flagRouted[gi]),
				.invert(polarity_r[gi]),
				.fromPin(flagPinIn[gi]),
				.fromCore(intFlags[gi]),
				.dirIn(flagDirIn[gi]),
				.toBus(flagBus[gi]),
				.toPin(flagPinOut[gi])
			);
		end
	endgenerate

	// per-lane checks, every lane not only the first
	genvar gc;
	generate
		for (gc = 0; gc < flag_irq_pkg::FLAG_N; gc++) begin : g_lane_chk
			// bus side: pin input inverted, everything else internal
			a_lane_bus: assert property (@(posedge core_clk) disable iff (rst)
				flagBus[gc] == ((flagRouted[gc] && flagDirIn[gc]) ? (flagPinIn[gc] ^ polarity_r[gc])
				: intFlags[gc]))
				else $error("flag bus lane wrong");
			// pin side: inversion only when the lane is routed
			a_lane_pin: assert property (@(posedge core_clk) disable iff (rst)
				flagPinOut[gc] == (intFlags[gc] ^ (flagRouted[gc] & polarity_r[gc])))
				else $error("flag pin lane wrong");
			// unrouted lane ignores its polarity bit
			a_lane_plain: assert property (@(posedge core_clk) disable iff (rst)
				!flagRouted[gc] |-> (flagBus[gc] == intFlags[gc]))
				else $error("unrouted lane not internal flag");
		end
	endgenerate

	// ************************************************************
	// start level
	// ************************************************************
	logic [5:0] startPol; // start polarity slice
	assign startPol = polarity_r[flag_irq_pkg::START_HI:flag_irq_pkg::START_LO];
	// start pins used as starts: 0 active high, 1 active low
	always_ff @(posedge core_clk) begin
		if (rst) begin
			startActive <= '0;
		end else begin
			// a start pin given over to a flag never starts anything
			startActive <= (startPinIn ^ startPol)
				& ~flagRouted[flag_irq_pkg::START_HI:flag_irq_pkg::START_LO];
		end
	end

	// per start pin level checks
	genvar gs;
	generate
		for (gs = 0; gs < flag_irq_pkg::START_N; gs++) begin : g_start_chk
			// level set by its polarity bit while used as a start
			a_start_pin: assert property (@(posedge core_clk) disable iff (rst)
				!flagRouted[flag_irq_pkg::START_LO + gs] |=> startActive[gs] ==
				($past(startPinIn[gs]) ^ $past(polarity_r[flag_irq_pkg::START_LO + gs])))
				else $error("start pin level wrong");
			// routed start pin stays inactive
			a_start_off: assert property (@(posedge core_clk) disable iff (rst)
				flagRouted[flag_irq_pkg::START_LO + gs] |=> !startActive[gs])
				else $error("routed start pin active");
		end
	endgenerate

	// ************************************************************
	// source gating
	// ************************************************************
	source_gate u_gate (
		.coreHalted(coreHalted),
		.coreRequest(coreRequest),
		.coreReqEn(coreReqEn),
		.driverDisabled(driverDisabled),
		.driverIrqEn(driverIrqEn),
		.spiError(spiError),
		.spiIrqEn(spiIrqEn),
		.clockLost(clockLost),
		.clockIrqEn(clockIrqEn),
		.codeSumBad(codeSumBad),
		.codeSumIrqEn(codeSumIrqEn),
		.src(srcBus.gate)
	);

	logic anySrc; // some enabled source active
	assign anySrc = |srcBus.active;

	// ************************************************************
	// combiner state and cause latch
	// ************************************************************
	// idle: capture on first source; held: freeze until all drop
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= flag_irq_pkg::IRQ_IDLE;
			cause_r <= flag_irq_pkg::CAUSE_RESET;
		end else begin
			case (state_r)
				flag_irq_pkg::IRQ_IDLE: begin
					if (anySrc) begin
						state_r <= flag_irq_pkg::IRQ_HELD;
						cause_r <= srcBus.active;
					end
				end
				flag_irq_pkg::IRQ_HELD: begin
					// cause kept while held
					if (!anySrc) begin
						state_r <= flag_irq_pkg::IRQ_IDLE;
						cause_r <= flag_irq_pkg::CAUSE_RESET;
					end
				end
				default: begin
					state_r <= flag_irq_pkg::IRQ_IDLE;
				end
			endcase
		end
	end

	// pin low while held
	always_ff @(posedge core_clk) begin
		if (rst) begin
			host_request_n_pin <= 1'b1;
		end else begin
			host_request_n_pin <= ~((state_r == flag_irq_pkg::IRQ_IDLE) ? anySrc
				: anySrc);
		end
	end

	// ************************************************************
	// register read
	// ************************************************************
	// read mux; unmapped reads zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			regRdata <= '0;
		end else if (regRd) begin
			if (regAddr == flag_irq_pkg::POL_ADDR) begin
				regRdata <= {3'h0, polarity_r};
			end else if (regAddr == flag_irq_pkg::CAUSE_ADDR) begin
				regRdata <= {3'h0, cause_r};
			end else begin
				regRdata <= '0;
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_pin_follows_src: assert property (@(posedge core_clk) disable iff (rst)
		anySrc |=> !host_request_n_pin)
		else $error("request pin not low after source");
	a_pin_release: assert property (@(posedge core_clk) disable iff (rst)
		!anySrc |=> host_request_n_pin && cause_r == 13'h0000)
		else $error("pin or cause not released");
	a_cause_capture: assert property (@(posedge core_clk) disable iff (rst)
		(state_r == flag_irq_pkg::IRQ_IDLE && anySrc) |=> cause_r == $past(srcBus.active))
		else $error("cause not captured");
	a_cause_frozen: assert property (@(posedge core_clk) disable iff (rst)
		(state_r == flag_irq_pkg::IRQ_HELD && anySrc) |=> $stable(cause_r))
		else $error("cause changed while held");
	a_cause_ro: assert property (@(posedge core_clk) disable iff (rst)
		(regWr && regAddr == flag_irq_pkg::CAUSE_ADDR && state_r == flag_irq_pkg::IRQ_HELD
		&& anySrc) |=> $stable(cause_r))
		else $error("cause written");
	a_pol_write: assert property (@(posedge core_clk) disable iff (rst)
		(regWr && regAddr == flag_irq_pkg::POL_ADDR) |=> polarity_r == $past(regWdata[12:0]))
		else $error("polarity not written");
	a_unrouted_pass: assert property (@(posedge core_clk) disable iff (rst)
		flagBus[0] == (flagRouted[0] && flagDirIn[0] ? flagPinIn[0] ^ polarity_r[0]
		: intFlags[0]))
		else $error("flag lane wrong");
	a_cause_read: assert property (@(posedge core_clk) disable iff (rst)
		(regRd && regAddr == flag_irq_pkg::CAUSE_ADDR) |=> regRdata[12:0] == $past(cause_r))
		else $error("cause read wrong");
	a_start_level: assert property (@(posedge core_clk) disable iff (rst)
		!flagRouted[3] |=> startActive[0] == ($past(startPinIn[0]) ^ $past(polarity_r[3])))
		else $error("start level wrong");

	// ************************************************************
	// source gating checks
	// ************************************************************
	// halt bits reach the cause layout with no enable
	a_halt_direct: assert property (@(posedge core_clk) disable iff (rst)
		srcBus.active[flag_irq_pkg::HALT_LO +: 4] == coreHalted)
		else $error("halt bits misplaced");
	// core requests gated by their own enables
	a_req_gated: assert property (@(posedge core_clk) disable iff (rst)
		srcBus.active[flag_irq_pkg::REQ_LO +: 4] == (coreRequest & coreReqEn))
		else $error("core request gating wrong");
	// driver disable source and its enable
	a_drv_gated: assert property (@(posedge core_clk) disable iff (rst)
		srcBus.active[flag_irq_pkg::DRV_BIT] == (driverDisabled && driverIrqEn))
		else $error("driver source gating wrong");
	// spi error source and its enable
	a_spi_gated: assert property (@(posedge core_clk) disable iff (rst)
		srcBus.active[flag_irq_pkg::SPI_BIT] == (spiError && spiIrqEn))
		else $error("spi source gating wrong");
	// clock loss source and its enable
	a_clk_gated: assert property (@(posedge core_clk) disable iff (rst)
		srcBus.active[flag_irq_pkg::CLK_BIT] == (clockLost && clockIrqEn))
		else $error("clock source gating wrong");
	// both checksum sources, channel 1 in the lower bit
	a_sum_gated: assert property (@(posedge core_clk) disable iff (rst)
		srcBus.active[flag_irq_pkg::SUM2_BIT:flag_irq_pkg::SUM1_BIT] == (codeSumBad & codeSumIrqEn))
		else $error("checksum source gating wrong");

	// ************************************************************
	// combiner checks
	// ************************************************************
	// pin level and state always agree, so the cause freeze tracks the pin
	a_pin_state: assert property (@(posedge core_clk) disable iff (rst)
		(state_r == flag_irq_pkg::IRQ_HELD) == !host_request_n_pin)
		else $error("pin and state disagree");
	// idle means an empty cause word
	a_idle_empty: assert property (@(posedge core_clk) disable iff (rst)
		(state_r == flag_irq_pkg::IRQ_IDLE) |-> cause_r == flag_irq_pkg::CAUSE_RESET)
		else $error("cause not empty while idle");
	// a halt alone is latched on entry
	a_halt_latch: assert property (@(posedge core_clk) disable iff (rst)
		(state_r == flag_irq_pkg::IRQ_IDLE && coreHalted[0]) |=> cause_r[flag_irq_pkg::HALT_LO])
		else $error("halt not latched");

	// ************************************************************
	// register port checks
	// ************************************************************
	// polarity only moves on a write to its own address
	a_pol_hold: assert property (@(posedge core_clk) disable iff (rst)
		!(regWr && regAddr == flag_irq_pkg::POL_ADDR) |=> $stable(polarity_r))
		else $error("polarity changed without write");
	// polarity read back with the unused top bits zero
	a_pol_read: assert property (@(posedge core_clk) disable iff (rst)
		(regRd && regAddr == flag_irq_pkg::POL_ADDR) |=> regRdata == {3'h0, $past(polarity_r)})
		else $error("polarity read wrong");
	// unmapped reads answer zero
	a_read_zero: assert property (@(posedge core_clk) disable iff (rst)
		(regRd && regAddr != flag_irq_pkg::POL_ADDR && regAddr != flag_irq_pkg::CAUSE_ADDR)
		|=> regRdata == 16'h0000)
		else $error("unmapped read not zero");
endmodule

// ************************************************************
// source gate
// ************************************************************
module source_gate (
	input wire logic [3:0] coreHalted,
	input wire logic [3:0] coreRequest,
	input wire logic [3:0] coreReqEn,
	input wire logic driverDisabled,
	input wire logic driverIrqEn,
	input wire logic spiError,
	input wire logic spiIrqEn,
	input wire logic clockLost,
	input wire logic clockIrqEn,
	input wire logic [1:0] codeSumBad,
	input wire logic [1:0] codeSumIrqEn,
	source_bus_if.gate src
);
	// pack enabled sources in cause layout
	always_comb begin
		src.active = '0;
		src.active[3:0] = coreHalted;
		src.active[7:4] = coreRequest & coreReqEn;
		src.active[8] = driverDisabled & driverIrqEn;
		src.active[9] = spiError & spiIrqEn;
		src.active[10] = clockLost & clockIrqEn;
		src.active[12:11] = codeSumBad & codeSumIrqEn;
	end
endmodule

// file: dv/mcu_host_model.sv
// Purpose: host controller model fetching the cause word on each request
// Assumes: request pin active low; one-cycle read strobe on the register port
// Notes: one read per falling edge of the request pin
`timescale 1ns/10ps
module mcu_host_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic host_request_n_pin,
	output logic rdReq,
	output logic [9:0] rdAddr
);
	logic pinPrev_r; // pin level one edge ago
	// ************************************************************
	// cause fetch
	// ************************************************************
	// a new request earns exactly one read of the cause word
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pinPrev_r <= 1'b1;
			rdReq <= 1'b0;
		end else begin
			pinPrev_r <= host_request_n_pin;
			rdReq <= pinPrev_r & ~host_request_n_pin;
		end
	end
	assign rdAddr = flag_irq_pkg::CAUSE_ADDR; // always the cause word
endmodule

// file: dv/flag_irq_top_tb.sv
// Purpose: self-checking bench for flag polarity and irq combiner
// Assumes: registered read data one cycle after the strobe
// Notes: read answers are checked against a queue of expected words
`timescale 1ns/10ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin badCount++; \
$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module flag_irq_top_tb;
	logic core_clk = 0, rst = 1, regWr = 0, tbRd = 0, mcuRd, pinN, rdPend = 0;
	logic [9:0] tbAddr = 0, mcuAddr, regAddr;
	logic [15:0] regWdata = 0, regRdata, expW;
	logic [12:0] routed = 0, dirIn = 0, pinIn = 0, intF = 0, flagBus, pinOut, pol = 0;
	logic [12:0] src = 0, en = 0; // sources and enables, cause layout
	logic [5:0] startIn = 0, startAct;
	logic [15:0] expQ[$]; // expected read answers, oldest first
	logic [31:0] seed = 43375;
	int badCount = 0, checksDone = 0;
	always #5 core_clk = ~core_clk;
	assign regAddr = mcuRd ? mcuAddr : tbAddr; // host model owns its reads
	flag_irq_top uut(.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWr(regWr),
		.regRd(tbRd | mcuRd), .regWdata(regWdata), .regRdata(regRdata), .flagRouted(routed),
		.flagDirIn(dirIn), .flagPinIn(pinIn), .intFlags(intF), .flagBus(flagBus),
		.flagPinOut(pinOut), .startPinIn(startIn), .startActive(startAct),
		.coreHalted(src[3:0]), .coreRequest(src[7:4]), .coreReqEn(en[7:4]),
		.driverDisabled(src[8]), .driverIrqEn(en[8]), .spiError(src[9]), .spiIrqEn(en[9]),
		.clockLost(src[10]), .clockIrqEn(en[10]), .codeSumBad(src[12:11]),
		.codeSumIrqEn(en[12:11]), .host_request_n_pin(pinN));
	mcu_host_model mcu(.core_clk(core_clk), .rst(rst), .host_request_n_pin(pinN),
		.rdReq(mcuRd), .rdAddr(mcuAddr));
	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tick(int n = 1);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic completeRun();
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wrReg(logic [9:0] a, logic [15:0] d);
		tbAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		tick();
		regWr <= 1'b0;
		tick();
	endtask
	task automatic rdReg(logic [9:0] a, logic [15:0] e);
		expQ.push_back(e);
		tbAddr <= a;
		tbRd <= 1'b1;
		tick();
		tbRd <= 1'b0;
		tick(2);
	endtask
	// bounded wait for the request pin, checked mid-cycle
	task automatic waitPin(logic v);
		for (int i = 0; i < 20 && pinN !== v; i++) @(negedge core_clk);
		`CHK(pinN, v)
		if (pinN !== v) completeRun();
		@(posedge core_clk);
	endtask
	// read answer checker: each answer against the oldest note
	always @(posedge core_clk) begin
		rdPend <= tbRd | mcuRd;
		if (rdPend) begin
			expW = (expQ.size() > 0) ? expQ.pop_front() : 16'hdead;
			`CHK(regRdata, expW)
		end
	end
	initial begin
		#300000;
		badCount++;
		$display("unexpected at %0t: run too long", $time);
		completeRun();
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		tick(16);
		rst <= 1'b0;
		tick();
		waitPin(1'b1);
		rdReg(flag_irq_pkg::POL_ADDR, 16'h0000);
		rdReg(flag_irq_pkg::CAUSE_ADDR, 16'h0000);
		// random polarity, routing and pin levels
		for (int i = 0; i < 16; i++) begin
			pol = 13'(rnd());
			wrReg(flag_irq_pkg::POL_ADDR, {3'h7, pol});
			rdReg(flag_irq_pkg::POL_ADDR, {3'h0, pol});
			routed <= 13'(rnd());
			dirIn <= 13'(rnd());
			pinIn <= 13'(rnd());
			intF <= 13'(rnd());
			startIn <= 6'(rnd());
			tick(2);
			@(negedge core_clk);
			`CHK(flagBus, (routed & dirIn & (pinIn ^ pol)) | (~(routed & dirIn) & intF))
			`CHK(pinOut & routed & ~dirIn, (intF ^ pol) & routed & ~dirIn)
			`CHK(startAct, ~routed[8:3] & (startIn ^ pol[8:3]))
			@(posedge core_clk);
		end
		// enabled sources stay silent while disabled
		src <= 13'h1ff0;
		tick(4);
		@(negedge core_clk);
		`CHK(pinN, 1'b1)
		@(posedge core_clk);
		src <= 13'h0000;
		en <= 13'h1fff;
		tick(2);
		// every source alone, fetched by the host model
		for (int b = 0; b < 13; b++) begin
			src <= 13'h0001 << b;
			expQ.push_back(16'h0001 << b);
			waitPin(1'b0);
			tick(6);
			src <= 13'h0000;
			waitPin(1'b1);
		end
		// late source while held: cause frozen, writes ignored
		src <= 13'h0100;
		expQ.push_back(16'h0100);
		waitPin(1'b0);
		src <= 13'h1300;
		tick(6);
		wrReg(flag_irq_pkg::CAUSE_ADDR, 16'hffff);
		rdReg(flag_irq_pkg::CAUSE_ADDR, 16'h0100);
		src <= 13'h0000;
		waitPin(1'b1);
		rdReg(flag_irq_pkg::CAUSE_ADDR, 16'h0000);
		`CHK(expQ.size(), 0)
		completeRun();
	end
endmodule
